// file: inc/far_defs.vh
// Constants for the feeder auto-reclose sequencer: timing, register map, fields
`ifndef FAR_DEFS_VH
`define FAR_DEFS_VH

// Timing: 200 MHz clock, 1 ms time base tick for all sequence timers
`define FAR_CLK_NS        5
`define FAR_TICK_NS       1000000
`define FAR_TICK_CYC      18'd200000 // FAR_TICK_NS / FAR_CLK_NS, sized for the tick counter
`define FAR_TICK_W        18

// Widths
`define FAR_TIME_W        20
`define FAR_CHANS         5
`define FAR_SHOTS         4
`define FAR_MEM_AW        6
`define FAR_MEM_WORDS     40

// Register byte offsets
`define FAR_ADDR_W        12
`define FAR_OFF_CTRL      12'h000
`define FAR_OFF_STATUS    12'h004
`define FAR_OFF_OVERALL   12'h008
`define FAR_OFF_SHOTEN    12'h00c
`define FAR_TIME_PAGE     4'h1

// Control register fields
`define FAR_CTRL_EN       0
`define FAR_CTRL_OVRLOCK  1
`define FAR_CTRL_NOOVR    2
`define FAR_CTRL_LOCKRST  3

// Reset values
`define FAR_CTRL_RST      3'h1
`define FAR_OVERALL_RST   20'h00000
`define FAR_SHOTEN_RST    20'h00000

// Status register fields
`define FAR_ST_ATTEMPT    8
`define FAR_ST_RUNNING    12
`define FAR_ST_CLOSE      13
`define FAR_ST_OVERALL    14
`define FAR_ST_LOCK       15
`define FAR_ST_STATE      16

`endif

// file: logic/far_time_mem.v
// Setting memory holding dead and reclaim times per channel and shot
`timescale 1ns/10ps
`default_nettype none
`include "far_defs.vh"

module far_time_mem (
	input  wire                       clk,      // System clock
	input  wire                       rst,      // Async reset, active high
	input  wire                       wrEn,     // Write strobe
	input  wire [`FAR_MEM_AW-1:0]     wrAddr,   // Write index
	input  wire [`FAR_TIME_W-1:0]     wrData,   // Write data in ms
	input  wire [`FAR_MEM_AW-1:0]     rdAddrA,  // Sequencer read index
	output reg  [`FAR_TIME_W-1:0]     rdDataA,  // Sequencer read data
	input  wire [`FAR_MEM_AW-1:0]     rdAddrB,  // Bus read index
	output reg  [`FAR_TIME_W-1:0]     rdDataB   // Bus read data
);

	reg [`FAR_TIME_W-1:0] mem [0:(1<<`FAR_MEM_AW)-1];

	// Storage has no reset; the sequencer is enabled from reset, before software loads the times
	always @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Both read ports are registered
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdDataA <= {`FAR_TIME_W{1'b0}};
			rdDataB <= {`FAR_TIME_W{1'b0}};
		end else begin
			rdDataA <= mem[rdAddrA];
			rdDataB <= mem[rdAddrB];
		end
	end

endmodule // far_time_mem
`default_nettype wire

// file: logic/far_timer.v
// Millisecond down-counter shared by dead, reclaim and overall periods
`timescale 1ns/10ps
`default_nettype none
`include "far_defs.vh"

module far_timer (
	input  wire                   clk,      // System clock
	input  wire                   rst,      // Async reset, active high
	input  wire                   clear,    // Hold idle
	input  wire                   load,     // Start with loadValue
	input  wire [`FAR_TIME_W-1:0] loadValue,// Period in ticks
	input  wire                   tick,     // 1 ms time base
	output reg                    done      // Period over, level
);

	reg [`FAR_TIME_W-1:0] count;
	reg                   armed;
	reg                   primed;

	// A zero period reports done right after loading, so it is skipped.
	// The tick runs free, so the first tick after loading only opens the
	// count: a period may run up to one tick long but never short.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count  <= {`FAR_TIME_W{1'b0}};
			armed  <= 1'b0;
			primed <= 1'b0;
			done   <= 1'b0;
		end else if (clear) begin
			count  <= {`FAR_TIME_W{1'b0}};
			armed  <= 1'b0;
			primed <= 1'b0;
			done   <= 1'b0;
		end else if (load) begin
			count  <= loadValue;
			armed  <= 1'b1;
			primed <= 1'b0;
			done   <= 1'b0;
		end else if (armed) begin
			if (count == {`FAR_TIME_W{1'b0}}) begin
				armed <= 1'b0;
				done  <= 1'b1;
			end else if (tick & ~primed) begin
				primed <= 1'b1; // Partial first tick period is not counted
			end else if (tick) begin
				count <= count - {{(`FAR_TIME_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // far_timer
`default_nettype wire

// file: logic/far_sequencer.v
// Auto-reclose sequencer with APB settings and breaker object handshake
//
// What this block does
// - Trip-driven request starts the sequence at once, no added start delay.
// - First request sets running, channel request and first-shot flags together.
// - Dead timer starts once breaker is open and the request is released.
// - Dead time over gives close request; object closes when conditions allow.
// - Close request drops on breaker closed; shot reclaim timer starts then.
// - Each channel has several enabled shots, each with its own dead time.
// - Request during reclaim with a further shot advances to that shot.
// - Second shot dead time expiry also issues a close request.
// - Request in last shot reclaim gives final trip, clears flags, locks.
// - Lockout holds until reset or re-initialisation by breaker closing.
// - Reclaim expiry clears flags, then starts the overall reclaim timer.
// - Fault in shot reclaim goes to the next shot, not to final trip.
// - Fault in overall reclaim gives final trip and lockout, by setting.
// - Zero reclaim or dead times are skipped entirely.
// - A setting omits the overall reclaim period after success.
// - Overall reclaim expiry returns the sequencer to ready.
// - Five ranked request inputs plus one critical request that halts all.
// - Object open or close failure always forces lockout.
// - Lockout clears by external reset input or by the breaker closing.
`timescale 1ns/10ps
`default_nettype none
`include "far_defs.vh"

module far_sequencer #(
	parameter [`FAR_TICK_W-1:0] TICK_CYCLES = `FAR_TICK_CYC // Cycles per 1 ms tick
) (
	input  wire                     clk,                  // 200 MHz clock
	input  wire                     rst,                  // Async reset, active high
	input  wire                     psel,                 // APB select
	input  wire                     penable,              // APB enable
	input  wire                     pwrite,               // APB direction
	input  wire [`FAR_ADDR_W-1:0]   paddr,                // APB byte address
	input  wire [31:0]              pwdata,               // APB write data
	output reg  [31:0]              prdata,               // APB read data
	output reg                      pready,               // APB ready
	output reg                      pslverr,              // APB error
	input  wire [`FAR_CHANS-1:0]    recloseRequest,       // Stage trips, bit 0 highest
	input  wire                     criticalRequest,      // Halt reclosing
	input  wire                     breakerOpen,          // Breaker open indication
	input  wire                     breakerClosed,        // Breaker closed indication
	input  wire                     objectFail,           // Object failure acknowledge
	input  wire                     lockResetIn,          // External lockout reset
	output reg                      recloserActiveFlag,   // Sequence running
	output reg  [`FAR_SHOTS-1:0]    attemptActive,        // Shot running, one-hot
	output reg  [`FAR_CHANS-1:0]    requestPendingFlag,   // Active request channel
	output reg                      overallSettlePeriod,  // Overall reclaim running
	output reg                      recloseLockedState,   // Lockout
	output reg                      closeRequest,         // Close request to object
	output reg                      finalTrip             // Final trip pulse
);

	localparam [2:0] S_READY   = 3'h0;
	localparam [2:0] S_OPENWT  = 3'h1;
	localparam [2:0] S_DEAD    = 3'h2;
	localparam [2:0] S_CLOSE   = 3'h3;
	localparam [2:0] S_RECLAIM = 3'h4;
	localparam [2:0] S_OVERALL = 3'h5;
	localparam [2:0] S_LOCK    = 3'h6;

	localparam NIN = `FAR_CHANS + 5;

	wire [NIN-1:0] rawIn = {lockResetIn, objectFail, breakerClosed, breakerOpen,
		criticalRequest, recloseRequest};
	reg  [NIN-1:0] syncA;
	reg  [NIN-1:0] syncB;

	// Two-stage synchronisers for every pin input
	genvar g;
	generate
		for (g = 0; g < NIN; g = g + 1) begin : gSync
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					syncA[g] <= 1'b0;
					syncB[g] <= 1'b0;
				end else begin
					syncA[g] <= rawIn[g];
					syncB[g] <= syncA[g];
				end
			end
		end
	endgenerate

	wire [`FAR_CHANS-1:0] req = syncB[`FAR_CHANS-1:0];
	wire crit     = syncB[`FAR_CHANS];
	wire brkOpen  = syncB[`FAR_CHANS+1];
	wire brkClose = syncB[`FAR_CHANS+2];
	wire objFail  = syncB[`FAR_CHANS+3];
	wire extReset = syncB[`FAR_CHANS+4];

	// Time base tick, 1 ms
	reg [`FAR_TICK_W-1:0] tickCount;
	reg                   tick;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCount <= {`FAR_TICK_W{1'b0}};
			tick      <= 1'b0;
		end else if (tickCount == TICK_CYCLES - {{(`FAR_TICK_W-1){1'b0}}, 1'b1}) begin
			tickCount <= {`FAR_TICK_W{1'b0}};
			tick      <= 1'b1;
		end else begin
			tickCount <= tickCount + {{(`FAR_TICK_W-1){1'b0}}, 1'b1};
			tick      <= 1'b0;
		end
	end

	// Settings
	reg  [2:0]                     ctrl;
	reg  [`FAR_TIME_W-1:0]         overallTime;
	reg  [`FAR_CHANS*`FAR_SHOTS-1:0] shotEnable;
	reg                            swLockReset;
	reg  [2:0]                     state;
	reg  [2:0]                     prevState;
	reg  [2:0]                     chan;
	reg  [1:0]                     shot;
	reg                            timerLoad;
	reg  [`FAR_TIME_W-1:0]         loadValue;
	reg                            brkCloseQ;
	wire                           timerDone;
	wire [`FAR_TIME_W-1:0]         seqTime;
	wire [`FAR_TIME_W-1:0]         busTime;

	// APB decode: time words live in page 1, index {channel, shot, reclaim}
	wire       apbAcc  = psel & penable;
	wire       apbDone = apbAcc & pready;
	wire       inTime  = paddr[11:8] == `FAR_TIME_PAGE;
	wire [5:0] timeIdx = paddr[7:2];
	wire       aligned = paddr[1:0] == 2'b00;
	wire       mapped  = aligned & ((paddr == `FAR_OFF_CTRL) | (paddr == `FAR_OFF_STATUS) |
		(paddr == `FAR_OFF_OVERALL) | (paddr == `FAR_OFF_SHOTEN) |
		(inTime & (timeIdx < `FAR_MEM_WORDS)));
	wire       wrOk    = apbDone & pwrite & ~pslverr;

	reg [31:0] readMux;
	always @* begin
		readMux = 32'h00000000;
		if (inTime) begin
			readMux = {{(32-`FAR_TIME_W){1'b0}}, busTime};
		end else begin
			case (paddr)
				`FAR_OFF_CTRL:    readMux = {29'h0000000, ctrl};
				`FAR_OFF_STATUS:  readMux = {13'h0000, state, recloseLockedState,
					overallSettlePeriod, closeRequest, recloserActiveFlag, attemptActive,
					3'h0, requestPendingFlag};
				`FAR_OFF_OVERALL: readMux = {{(32-`FAR_TIME_W){1'b0}}, overallTime};
				`FAR_OFF_SHOTEN:  readMux = {12'h000, shotEnable};
				default:          readMux = 32'h00000000;
			endcase
		end
	end

	// One wait state: memory read data is registered, answer in second access cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (apbAcc & ~pready) begin
			pready  <= 1'b1;
			pslverr <= ~mapped;
			prdata  <= (pwrite | ~mapped) ? 32'h00000000 : readMux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register writes take effect at the completing edge only
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl        <= `FAR_CTRL_RST;
			overallTime <= `FAR_OVERALL_RST;
			shotEnable  <= `FAR_SHOTEN_RST;
			swLockReset <= 1'b0;
		end else begin
			swLockReset <= wrOk & (paddr == `FAR_OFF_CTRL) & pwdata[`FAR_CTRL_LOCKRST];
			if (wrOk & (paddr == `FAR_OFF_CTRL))
				ctrl <= pwdata[2:0];
			if (wrOk & (paddr == `FAR_OFF_OVERALL))
				overallTime <= pwdata[`FAR_TIME_W-1:0];
			if (wrOk & (paddr == `FAR_OFF_SHOTEN))
				shotEnable <= pwdata[`FAR_CHANS*`FAR_SHOTS-1:0];
		end
	end

	far_time_mem uMem (
		.clk     (clk),
		.rst     (rst),
		.wrEn    (wrOk & inTime),
		.wrAddr  (timeIdx),
		.wrData  (pwdata[`FAR_TIME_W-1:0]),
		.rdAddrA ({chan, shot, state == S_CLOSE}),
		.rdDataA (seqTime),
		.rdAddrB (timeIdx),
		.rdDataB (busTime)
	);

	far_timer uTimer (
		.clk       (clk),
		.rst       (rst),
		.clear     ((state == S_READY) | (state == S_LOCK)),
		.load      (timerLoad),
		.loadValue (loadValue),
		.tick      (tick),
		.done      (timerDone)
	);

	// Highest ranked active request; bit 0 wins
	reg       newReq;
	reg [2:0] newChan;
	integer   i;
	always @* begin
		newReq  = 1'b0;
		newChan = 3'h0;
		for (i = `FAR_CHANS - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				newReq  = 1'b1;
				newChan = i[2:0];
			end
		end
	end

	// State age guards stale timer done and memory data just after a move
	wire settled   = state == prevState;
	wire firstEn   = shotEnable[{newChan, 2'b00}];
	wire nextAvail = (shot != 2'b11) & shotEnable[{newChan, shot + 2'b01}];
	wire brkRise   = brkClose & ~brkCloseQ;

	// Sequencer; all status outputs are registered here
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state               <= S_READY;
			prevState           <= S_READY;
			chan                <= 3'h0;
			shot                <= 2'h0;
			timerLoad           <= 1'b0;
			loadValue           <= {`FAR_TIME_W{1'b0}};
			brkCloseQ           <= 1'b0;
			recloserActiveFlag  <= 1'b0;
			attemptActive       <= {`FAR_SHOTS{1'b0}};
			requestPendingFlag  <= {`FAR_CHANS{1'b0}};
			overallSettlePeriod <= 1'b0;
			recloseLockedState  <= 1'b0;
			closeRequest        <= 1'b0;
			finalTrip           <= 1'b0;
		end else begin
			prevState <= state;
			brkCloseQ <= brkClose;
			timerLoad <= 1'b0;
			finalTrip <= 1'b0;
			if ((crit | objFail) & (state != S_LOCK)) begin
				// Critical request or failed object command halts everything
				state               <= S_LOCK;
				recloserActiveFlag  <= 1'b0;
				attemptActive       <= {`FAR_SHOTS{1'b0}};
				requestPendingFlag  <= {`FAR_CHANS{1'b0}};
				overallSettlePeriod <= 1'b0;
				closeRequest        <= 1'b0;
				recloseLockedState  <= 1'b1;
				finalTrip           <= 1'b1;
			end else begin
				case (state)
					S_READY, S_OVERALL: begin
						if (ctrl[`FAR_CTRL_EN] & newReq) begin
							overallSettlePeriod <= 1'b0;
							if (((state == S_OVERALL) & ctrl[`FAR_CTRL_OVRLOCK]) | ~firstEn) begin
								state              <= S_LOCK;
								recloseLockedState <= 1'b1;
								finalTrip          <= 1'b1;
							end else begin
								// No start delay: the trip itself starts the shot
								state                       <= S_OPENWT;
								recloserActiveFlag          <= 1'b1;
								requestPendingFlag          <= {`FAR_CHANS{1'b0}};
								requestPendingFlag[newChan] <= 1'b1;
								attemptActive               <= {{(`FAR_SHOTS-1){1'b0}}, 1'b1};
								chan                        <= newChan;
								shot                        <= 2'h0;
							end
						end else if ((state == S_OVERALL) & settled & timerDone) begin
							state               <= S_READY;
							overallSettlePeriod <= 1'b0;
						end
					end
					S_OPENWT: begin
						// The stage opened the breaker; only wait for it here
						if (settled & brkOpen & ~req[chan]) begin
							state     <= S_DEAD;
							timerLoad <= 1'b1;
							loadValue <= seqTime;
						end
					end
					S_DEAD: begin
						if (settled & timerDone) begin
							state        <= S_CLOSE;
							closeRequest <= 1'b1;
						end
					end
					S_CLOSE: begin
						if (settled & brkClose) begin
							state        <= S_RECLAIM;
							closeRequest <= 1'b0;
							timerLoad    <= 1'b1;
							loadValue    <= seqTime;
						end
					end
					S_RECLAIM: begin
						if (newReq & nextAvail) begin
							// Evolving fault may move to a higher ranked channel
							state                       <= S_OPENWT;
							chan                        <= newChan;
							shot                        <= shot + 2'h1;
							attemptActive               <= {attemptActive[`FAR_SHOTS-2:0], 1'b0};
							requestPendingFlag          <= {`FAR_CHANS{1'b0}};
							requestPendingFlag[newChan] <= 1'b1;
						end else if (newReq) begin
							state              <= S_LOCK;
							recloserActiveFlag <= 1'b0;
							attemptActive      <= {`FAR_SHOTS{1'b0}};
							requestPendingFlag <= {`FAR_CHANS{1'b0}};
							recloseLockedState <= 1'b1;
							finalTrip          <= 1'b1;
						end else if (settled & timerDone) begin
							recloserActiveFlag <= 1'b0;
							attemptActive      <= {`FAR_SHOTS{1'b0}};
							requestPendingFlag <= {`FAR_CHANS{1'b0}};
							if (ctrl[`FAR_CTRL_NOOVR] | (overallTime == {`FAR_TIME_W{1'b0}})) begin
								state <= S_READY;
							end else begin
								state               <= S_OVERALL;
								overallSettlePeriod <= 1'b1;
								timerLoad           <= 1'b1;
								loadValue           <= overallTime;
							end
						end
					end
					S_LOCK: begin
						// Requests are ignored until reset or a fresh breaker close
						if (extReset | swLockReset | brkRise) begin
							state              <= S_READY;
							recloseLockedState <= 1'b0;
						end
					end
					default: begin
						state <= S_READY;
					end
				endcase
			end
		end
	end

endmodule // far_sequencer
`default_nettype wire

// file: tb/far_seq_monitor.sv
// Port checker for the reclose sequencer
`timescale 1ns/10ps
`default_nettype none
module far_seq_monitor (
	input wire logic       clk,                 // Clock
	input wire logic       rst,                 // Reset
	input wire logic       psel,                // Select
	input wire logic       penable,             // Enable
	input wire logic       pready,              // Ready
	input wire logic       breakerOpen,         // Open pin
	input wire logic       breakerClosed,       // Closed pin
	input wire logic       recloserActiveFlag,  // Running
	input wire logic [3:0] attemptActive,       // Shot flags
	input wire logic [4:0] requestPendingFlag,  // Channel flags
	input wire logic       overallSettlePeriod, // Overall reclaim
	input wire logic       recloseLockedState,  // Lockout
	input wire logic       closeRequest,        // Close request
	input wire logic       finalTrip            // Final trip
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Bus answer comes in the second access cycle and lasts one cycle
	a_apb_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	// Flags stay one-hot so a single shot and channel are named
	a_shot_onehot: assert property ($onehot0(attemptActive))
		else $error("shot flags not one-hot");
	a_chan_onehot: assert property ($onehot0(requestPendingFlag))
		else $error("channel flags not one-hot");
	// Running, shot and channel flags rise and fall as one group
	a_flags_together: assert property ((|attemptActive) == recloserActiveFlag
		&& (|requestPendingFlag) == recloserActiveFlag)
		else $error("flags out of step");
	a_overall_idle: assert property (overallSettlePeriod |-> !recloserActiveFlag
		&& !recloseLockedState)
		else $error("overall period overlaps a run");
	a_lock_quiet: assert property (recloseLockedState |-> !closeRequest
		&& !recloserActiveFlag)
		else $error("activity in lockout");
	a_trip_pulse: assert property (finalTrip |=> !finalTrip && recloseLockedState)
		else $error("final trip not a pulse into lockout");
	a_close_drop: assert property (closeRequest && breakerClosed |-> ##[1:5] !closeRequest)
		else $error("close request kept after closed");
	a_close_open: assert property ($rose(closeRequest) |-> breakerOpen
		&& recloserActiveFlag)
		else $error("close request without open breaker");
endmodule // far_seq_monitor

bind far_sequencer far_seq_monitor u_mon (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.breakerOpen(breakerOpen), .breakerClosed(breakerClosed),
	.recloserActiveFlag(recloserActiveFlag), .attemptActive(attemptActive),
	.requestPendingFlag(requestPendingFlag), .overallSettlePeriod(overallSettlePeriod),
	.recloseLockedState(recloseLockedState), .closeRequest(closeRequest),
	.finalTrip(finalTrip)
);
`default_nettype wire

// file: tb/far_breaker_model.sv
// Breaker object model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module far_breaker_model #(
	parameter int CLOSE_DLY = 3 // Cycles from request to closed, less one
) (
	input wire logic clk,           // Clock
	input wire logic rst,           // Reset
	input wire logic closeRequest,  // From sequencer
	input wire logic openCmd,       // Stage trip opens breaker
	input wire logic manualClose,   // Operator close
	output var logic breakerOpen,   // Open indication
	output var logic breakerClosed  // Closed indication
);
	int cnt;

	// Breaker starts closed; close waits until conditions are met
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			breakerClosed <= 1'b1;
			cnt <= 0;
		end else if (openCmd) begin
			breakerClosed <= 1'b0;
			cnt <= 0;
		end else if (manualClose) begin
			breakerClosed <= 1'b1;
		end else if (closeRequest && !breakerClosed) begin
			cnt <= cnt + 1;
			if (cnt == CLOSE_DLY) begin
				breakerClosed <= 1'b1;
			end
		end else begin
			cnt <= 0;
		end
	end
	assign breakerOpen = !breakerClosed;
endmodule // far_breaker_model
`default_nettype wire

// file: tb/far_sequencer_tb_top.sv
// Self-checking bench for the reclose sequencer
`timescale 1ns/10ps
`default_nettype none
module far_sequencer_tb_top;
	localparam int TK = 10; // Cycles per ms, shortens every period
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [4:0]  recloseRequest = 5'h00;
	logic        criticalRequest = 1'b0, objectFail = 1'b0, lockResetIn = 1'b0;
	logic        openCmd = 1'b0, manualClose = 1'b0;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, breakerOpen, breakerClosed, recloserActiveFlag;
	wire logic [3:0]  attemptActive;
	wire logic [4:0]  requestPendingFlag;
	wire logic        overallSettlePeriod, recloseLockedState, closeRequest, finalTrip;
	wire logic [11:0] fl = {recloserActiveFlag, attemptActive, requestPendingFlag,
		overallSettlePeriod, recloseLockedState};
	int n_mismatch = 0, n_compared = 0, nTrip = 0, n;

	always #2.5 clk = ~clk;

	far_sequencer #(.TICK_CYCLES(18'd10)) uut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .recloseRequest(recloseRequest),
		.criticalRequest(criticalRequest), .breakerOpen(breakerOpen),
		.breakerClosed(breakerClosed), .objectFail(objectFail), .lockResetIn(lockResetIn),
		.recloserActiveFlag(recloserActiveFlag), .attemptActive(attemptActive),
		.requestPendingFlag(requestPendingFlag), .overallSettlePeriod(overallSettlePeriod),
		.recloseLockedState(recloseLockedState), .closeRequest(closeRequest),
		.finalTrip(finalTrip));
	far_breaker_model bm (.clk(clk), .rst(rst), .closeRequest(closeRequest),
		.openCmd(openCmd), .manualClose(manualClose), .breakerOpen(breakerOpen),
		.breakerClosed(breakerClosed));

	// Count final trip pulses, each must last one cycle
	always @(posedge clk) begin
		if (finalTrip === 1'b1) nTrip++;
	end

	task end_sim;
		if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task tick(input int c);
		repeat (c) @(posedge clk);
	endtask

	// One bus transfer; held until ready is sampled, never longer than 20 cycles
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		chk("pslverr", pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			n_mismatch++;
			$display("Error pready expected 1 seen %b", pready);
			end_sim;
		end
	endtask

	// Bounded wait for an output level; n returns cycles taken
	task waitv(input int s, input logic v, input int lim, output int c);
		logic x;
		c = 0;
		do begin
			@(posedge clk);
			c++;
			x = (s == 0) ? closeRequest : overallSettlePeriod;
		end while (x !== v && c < lim);
		if (x !== v) begin
			n_mismatch++;
			$display("Error wait %0d expected %b seen %b", s, v, x);
			end_sim;
		end
	endtask

	// Stage trips and opens the breaker, then its trip output drops
	task trip(input logic [4:0] r);
		recloseRequest <= r;
		openCmd <= 1'b1;
		@(posedge clk);
		openCmd <= 1'b0;
		tick(6);
		recloseRequest <= 5'h00;
	endtask

	// Dead time from release of the trip, then object closes the breaker
	task reclose(input int ms);
		waitv(0, 1'b1, ms * TK + 40, n);
		chk("dead", n >= ms * TK && n <= ms * TK + TK + 20, 1);
		waitv(0, 1'b0, 20, n);
		chk("closed", breakerClosed, 1'b1);
	endtask

	initial begin
		tick(16);
		rst <= 1'b0;
		tick(2);
		chk("idle", fl, 12'h000);
		chk("close", closeRequest, 1'b0);
		apb(0, 12'h000, 0, 0);
		chk("ctrl", rd, 32'h1);
		apb(0, 12'h010, 0, 1);
		apb(1, 12'h004, 32'hffff, 0);
		apb(0, 12'h004, 0, 0);
		chk("status", rd, 32'h0);
		// Channel 0 shot 1 has no reclaim; channel 1 has two shots
		apb(1, 12'h100, 10, 0);
		apb(1, 12'h104, 0, 0);
		apb(1, 12'h120, 20, 0);
		apb(1, 12'h124, 30, 0);
		apb(1, 12'h128, 40, 0);
		apb(1, 12'h12c, 30, 0);
		apb(1, 12'h008, 50, 0);
		apb(1, 12'h00c, 32'h31, 0);
		apb(0, 12'h00c, 0, 0);
		chk("shoten", rd, 32'h31);
		// Both shots fail: advance, then final trip and lockout
		trip(5'h02);
		chk("shot1", fl, 12'h888);
		reclose(20);
		tick(20);
		trip(5'h02);
		chk("shot2", fl, 12'h908);
		reclose(40);
		tick(20);
		trip(5'h02);
		chk("final", fl, 12'h001);
		chk("trips", nTrip, 1);
		trip(5'h02);
		chk("held", fl, 12'h001);
		manualClose <= 1'b1;
		@(posedge clk);
		manualClose <= 1'b0;
		tick(6);
		chk("unlock", fl, 12'h000);
		// Priority pick and success with zero reclaim
		trip(5'h03);
		chk("prio", fl, 12'h884);
		reclose(10);
		waitv(1, 1'b1, 10, n);
		chk("overall", fl, 12'h002);
		waitv(1, 1'b0, 50 * TK + 30, n);
		chk("ovtime", n >= 50 * TK && n <= 50 * TK + TK + 10, 1);
		// Request during overall period locks when that mode is on
		apb(1, 12'h000, 32'h3, 0);
		trip(5'h01);
		reclose(10);
		waitv(1, 1'b1, 10, n);
		trip(5'h01);
		chk("ovlock", fl, 12'h001);
		apb(1, 12'h000, 32'hb, 0);
		tick(4);
		chk("swreset", fl, 12'h000);
		apb(0, 12'h000, 0, 0);
		chk("ctrl3", rd, 32'h3);
		// Overall period omitted after success
		apb(1, 12'h000, 32'h5, 0);
		trip(5'h01);
		reclose(10);
		tick(12);
		chk("omit", fl, 12'h000);
		// Critical request and object failure both lock
		trip(5'h02);
		criticalRequest <= 1'b1;
		tick(6);
		criticalRequest <= 1'b0;
		chk("crit", fl, 12'h001);
		lockResetIn <= 1'b1;
		tick(4);
		lockResetIn <= 1'b0;
		tick(4);
		chk("extreset", fl, 12'h000);
		trip(5'h02);
		objectFail <= 1'b1;
		tick(6);
		objectFail <= 1'b0;
		chk("objfail", fl, 12'h001);
		chk("trips4", nTrip, 4);
		end_sim;
	end
endmodule // far_sequencer_tb_top
`default_nettype wire
